// ==== verilog/sweep_mode_pkg.sv ====
package sweep_mode_pkg;

   // Serial word: four address bits over twelve data bits
   typedef struct packed {
      logic [3:0]  addr;
      logic [11:0] data;
   } serial_word_t;

   // Mode control word, bit 11 down to bit 0
   typedef struct packed {
      logic       pair_load;
      logic       dac_enable;
      logic       wave_shape_select;
      logic       square_out_enable;
      logic       continuous_or_gated;
      logic       gate_source_select;
      logic       step_source_select;
      logic       sweep_profile;
      logic       marker_select;
      logic       marker_out_enable;
      logic [1:0] fixed_ones;
   } mode_control_word_t;

   // Sweep parameters held by the neighbouring register block
   typedef struct packed {
      logic [11:0] step_count;
      logic        interval_in_cycles;
      logic [10:0] step_interval;
      logic        gate_in_cycles;
      logic [10:0] gate_interval;
   } sweep_params_t;

   localparam logic [3:0]  MODE_WORD_ADDR  = 4'h0;
   localparam logic [11:0] MODE_WORD_RESET = 12'h0003;

   localparam int unsigned MCLK_PERIOD_NS   = 40;
   localparam int unsigned MARKER_PULSE_NS  = 160;
   localparam logic [2:0]  MARKER_PULSE_CYC =
      3'((MARKER_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

endpackage

// ==== verilog/sweep_mode_control.sv ====
`timescale 1ns/1ns

// Behaviour
// - Shape bit one selects sine lookup output
// - Shape bit zero feeds phase as triangle
// - Square enable drives or floats square pin
// - Continuous mode holds each frequency whole window
// - Gated mode outputs only for gate interval
// - Rest of gated window sits at midscale
// - External gate follows trigger pin pulse widths
// - Gate source ignored unless stepping is external
// - Gate source one gates from trigger pin
// - Gate source zero times gate internally
// - Step source one steps on pin triggers
// - Step source zero steps on internal timer
// - Profile one gives sawtooth restart sweep
// - Profile zero gives up then down sweep
// - Marker select chooses end or step marker
// - End marker high until next sweep starts
// - Step marker pulses four clocks per step
// - Marker enable one drives marker pin
// - Marker enable zero floats marker pin
// - Address zero words load the mode word
// - Mode word write resets sweep, midscale output
// - Converter enable zero powers converter down
module sweep_mode_control #(
   parameter int PHASE_W = 12,
   parameter int DAC_W   = 10
) (
   input  wire logic                              core_clk,
   input  wire logic                              reset,
   input  wire logic                              clk_en,
   input  wire logic                              word_valid,
   input  wire sweep_mode_pkg::serial_word_t      word_in,
   input  wire sweep_mode_pkg::sweep_params_t     params,
   input  wire logic                              trigger_pin,
   input  wire logic                              out_cycle_tick,
   input  wire logic [PHASE_W-1:0]                phase_word,
   input  wire logic [DAC_W-1:0]                  sine_value,
   output      sweep_mode_pkg::mode_control_word_t mode_word,
   output      logic                              sine_lookup_en,
   output      logic [DAC_W-1:0]                  dac_code,
   output      logic                              dac_power_en,
   output      logic                              step_pulse,
   output      logic [11:0]                       step_index,
   output      logic                              step_down,
   output      logic                              sweep_done,
   output      logic                              square_out_pin_o,
   output      logic                              square_out_pin_oe,
   output      logic                              marker_pin_o,
   output      logic                              marker_pin_oe
);
   import sweep_mode_pkg::*;

   localparam logic [DAC_W-1:0] MIDSCALE = DAC_W'(1) << (DAC_W - 1);

   typedef enum logic {ST_IDLE, ST_RUN} sweep_state_t;

   function automatic logic [DAC_W-1:0] tri_of(
      input logic [PHASE_W-1:0] ph);
      logic [DAC_W-1:0] mag;
      mag = ph[PHASE_W-2 -: DAC_W];
      tri_of = ph[PHASE_W-1] ? ~mag : mag;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Trigger pin synchroniser
   logic trig_s1_q;
   logic trig_s2_q;
   logic trig_s3_q;
   logic trig_level_q;
   logic trig_level_d;
   logic trig_rise;

   always_comb begin
      trig_level_d = (trig_s2_q == trig_s3_q) ? trig_s3_q : trig_level_q;
      trig_rise    = trig_level_d & ~trig_level_q;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         trig_s1_q    <= 1'b0;
         trig_s2_q    <= 1'b0;
         trig_s3_q    <= 1'b0;
         trig_level_q <= 1'b0;
      end else if (clk_en) begin
         trig_s1_q    <= trigger_pin;
         trig_s2_q    <= trig_s1_q;
         trig_s3_q    <= trig_s2_q;
         trig_level_q <= trig_level_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Mode control word
   // Serial shifter hands over only whole words, so no half update
   mode_control_word_t ctrl_q;
   mode_control_word_t ctrl_d;
   logic               ctrl_wr;

   always_comb begin
      ctrl_wr = word_valid && (word_in.addr == MODE_WORD_ADDR);
      ctrl_d  = ctrl_q;
      if (ctrl_wr) begin
         ctrl_d = mode_control_word_t'(word_in.data);
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctrl_q <= mode_control_word_t'(MODE_WORD_RESET);
      end else if (clk_en) begin
         ctrl_q <= ctrl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Step and gate sequencing
   sweep_state_t st_q;
   sweep_state_t st_d;
   logic [10:0]  timer_q;
   logic [10:0]  timer_d;
   logic [11:0]  idx_q;
   logic [11:0]  idx_d;
   logic         down_q;
   logic         down_d;
   logic         eos_q;
   logic         eos_d;
   logic         run;
   logic         tick;
   logic         ext_gate;
   logic         gate_open;
   logic         step_evt;
   logic         int_expire;

   always_comb begin
      run  = (st_q == ST_RUN);
      tick = params.interval_in_cycles ? out_cycle_tick : 1'b1;
      int_expire = tick &&
         ({1'b0, timer_q} + 12'h0001 >= {1'b0, params.step_interval});
      // Pin gating only counts while stepping is external too
      ext_gate = !ctrl_q.continuous_or_gated &&
                 ctrl_q.step_source_select &&
                 ctrl_q.gate_source_select;
      if (ctrl_q.continuous_or_gated) begin
         gate_open = 1'b1;
      end else if (ext_gate) begin
         gate_open = trig_level_q;
      end else begin
         gate_open = timer_q < params.gate_interval;
      end
      if (ctrl_q.step_source_select) begin
         step_evt = run && trig_rise;
      end else begin
         step_evt = run && int_expire;
      end

      st_d    = st_q;
      timer_d = timer_q;
      idx_d   = idx_q;
      down_d  = down_q;
      eos_d   = eos_q;
      if (ctrl_wr) begin
         st_d    = ST_IDLE;
         timer_d = 11'h000;
         idx_d   = 12'h000;
         down_d  = 1'b0;
         eos_d   = 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (trig_rise) begin
                  st_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (step_evt) begin
                  timer_d = 11'h000;
                  if (eos_q) begin
                     eos_d  = 1'b0;
                     down_d = 1'b0;
                     idx_d  = ctrl_q.sweep_profile ? 12'h000 : 12'h001;
                  end else if (!down_q) begin
                     if (idx_q >= params.step_count) begin
                        if (ctrl_q.sweep_profile) begin
                           eos_d = 1'b1;
                        end else begin
                           down_d = 1'b1;
                           idx_d  = idx_q - 12'h001;
                        end
                     end else begin
                        idx_d = idx_q + 12'h001;
                     end
                  end else begin
                     idx_d = idx_q - 12'h001;
                     if (idx_q <= 12'h001) begin
                        idx_d = 12'h000;
                        eos_d = 1'b1;
                     end
                  end
               end else if (tick && timer_q != 11'h7ff) begin
                  timer_d = timer_q + 11'h001;
               end
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         st_q    <= ST_IDLE;
         timer_q <= 11'h000;
         idx_q   <= 12'h000;
         down_q  <= 1'b0;
         eos_q   <= 1'b0;
      end else if (clk_en) begin
         st_q    <= st_d;
         timer_q <= timer_d;
         idx_q   <= idx_d;
         down_q  <= down_d;
         eos_q   <= eos_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Converter code, square and marker pins
   logic [DAC_W-1:0] dac_q;
   logic [DAC_W-1:0] dac_d;
   logic             sq_q;
   logic             sq_d;
   logic [2:0]       mcnt_q;
   logic [2:0]       mcnt_d;
   logic             marker_q;
   logic             marker_d;
   logic             step_q;

   always_comb begin
      if (ctrl_wr || !run || !gate_open) begin
         dac_d = MIDSCALE;
      end else if (ctrl_q.wave_shape_select) begin
         dac_d = sine_value;
      end else begin
         dac_d = tri_of(phase_word);
      end
      sq_d = phase_word[PHASE_W-1];
      if (ctrl_wr) begin
         mcnt_d = 3'h0;
      end else if (step_evt) begin
         mcnt_d = MARKER_PULSE_CYC;
      end else if (mcnt_q != 3'h0) begin
         mcnt_d = mcnt_q - 3'h1;
      end else begin
         mcnt_d = 3'h0;
      end
      // Select only matters while the pin is driven
      marker_d = ctrl_d.marker_select ? eos_d : (mcnt_d != 3'h0);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         dac_q    <= MIDSCALE;
         sq_q     <= 1'b0;
         mcnt_q   <= 3'h0;
         marker_q <= 1'b0;
         step_q   <= 1'b0;
      end else if (clk_en) begin
         dac_q    <= dac_d;
         sq_q     <= sq_d;
         mcnt_q   <= mcnt_d;
         marker_q <= marker_d;
         step_q   <= step_evt;
      end
   end

   // Reserved ones from the host are stored but steer nothing
   assign mode_word         = ctrl_q;
   assign sine_lookup_en    = ctrl_q.wave_shape_select;
   assign dac_code          = dac_q;
   assign dac_power_en      = ctrl_q.dac_enable;
   assign step_pulse        = step_q;
   assign step_index        = idx_q;
   assign step_down         = down_q;
   assign sweep_done        = eos_q;
   assign square_out_pin_o  = sq_q;
   assign square_out_pin_oe = ctrl_q.square_out_enable;
   assign marker_pin_o      = marker_q;
   assign marker_pin_oe     = ctrl_q.marker_out_enable;

   ////////////////////////////////////////////////////////////////////
   // Checks
   sequence ctrl_write_s;
      clk_en && ctrl_wr;
   endsequence

   sequence step_s;
      clk_en && step_evt && !ctrl_wr;
   endsequence

   sequence pulse_hold_s;
      marker_q && (mcnt_q == MARKER_PULSE_CYC);
   endsequence

   word_load_a: assert property (@(posedge core_clk) disable iff (reset)
      ctrl_write_s |=> (ctrl_q == $past(word_in.data)))
      else $error("mode word not loaded");

   write_reset_a: assert property (@(posedge core_clk) disable iff (reset)
      ctrl_write_s |=> (st_q == ST_IDLE) && (dac_q == MIDSCALE)
                       && (idx_q == 12'h000))
      else $error("mode write did not reset sweep");

   pin_enables_a: assert property (@(posedge core_clk) disable iff (reset)
      ctrl_write_s |=> (square_out_pin_oe == $past(word_in.data[8]))
                       && (marker_pin_oe == $past(word_in.data[2]))
                       && (dac_power_en == $past(word_in.data[10])))
      else $error("pin enable mismatch");

   sine_path_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !ctrl_wr && run && gate_open && ctrl_q.wave_shape_select
      |=> dac_q == $past(sine_value))
      else $error("sine path wrong");

   tri_path_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !ctrl_wr && run && gate_open && !ctrl_q.wave_shape_select
      |=> dac_q == tri_of($past(phase_word)))
      else $error("triangle path wrong");

   gate_mid_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && run && !ctrl_q.continuous_or_gated && !ext_gate
      && (timer_q >= params.gate_interval) |=> dac_q == MIDSCALE)
      else $error("gated window not midscale");

   cont_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      ctrl_q.continuous_or_gated |-> gate_open)
      else $error("continuous mode gated");

   ext_gate_a: assert property (@(posedge core_clk) disable iff (reset)
      ext_gate |-> (gate_open == trig_level_q)
                   && ctrl_q.step_source_select)
      else $error("external gate wrong");

   ext_step_a: assert property (@(posedge core_clk) disable iff (reset)
      step_evt && ctrl_q.step_source_select |-> trig_rise)
      else $error("external step without trigger");

   int_step_a: assert property (@(posedge core_clk) disable iff (reset)
      step_evt && !ctrl_q.step_source_select |-> int_expire)
      else $error("internal step early");

   saw_restart_a: assert property (@(posedge core_clk) disable iff (reset)
      step_s and (eos_q && ctrl_q.sweep_profile)
      |=> (idx_q == 12'h000) && !eos_q)
      else $error("sawtooth did not restart");

   tri_turn_a: assert property (@(posedge core_clk) disable iff (reset)
      step_s and (!down_q && !eos_q && !ctrl_q.sweep_profile
                  && idx_q >= params.step_count) |=> down_q)
      else $error("triangle sweep did not turn");

   step_marker_a: assert property (@(posedge core_clk) disable iff (reset)
      step_s and !ctrl_q.marker_select |=> pulse_hold_s)
      else $error("step marker not started");

   end_marker_a: assert property (@(posedge core_clk) disable iff (reset)
      clk_en && !ctrl_wr && ctrl_q.marker_select
      |=> marker_q == eos_q)
      else $error("end marker mismatch");

endmodule // sweep_mode_control

// ==== test/sweep_host_model.sv ====
`timescale 1ns/1ns
module sweep_host_model (
   input  wire logic                         core_clk,
   output      logic                         word_valid,
   output      sweep_mode_pkg::serial_word_t word_in
);
   import sweep_mode_pkg::*;

   initial begin
      word_valid = 1'b0;
      word_in    = '0;
   end

   // One whole 16-bit word per call, held for one sampling edge
   task automatic send(input logic [3:0] addr, input logic [11:0] data);
      @(posedge core_clk);
      #1;
      word_valid   = 1'b1;
      word_in.addr = addr;
      word_in.data = (addr == 4'h0) ? (data | 12'h003) : data;
      @(posedge core_clk);
      #1;
      word_valid = 1'b0;
      // Released bus shows the inverse, not a stale copy
      word_in    = ~word_in;
   endtask
endmodule // sweep_host_model

// ==== test/sweep_mode_control_bench.sv ====
`timescale 1ns/1ns
module sweep_mode_control_bench;
   import sweep_mode_pkg::*;
   logic               core_clk = 1'b0;
   logic               reset = 1'b1;
   logic               clk_en = 1'b1;
   logic               word_valid;
   serial_word_t       word_in;
   sweep_params_t      params = '0;
   logic               trigger_pin = 1'b0;
   logic               out_cycle_tick = 1'b0;
   logic [11:0]        phase_word = 12'h000;
   logic [9:0]         sine_value = 10'h0ab;
   mode_control_word_t mode_word;
   logic [9:0]         dac_code;
   logic [11:0]        step_index;
   logic               sine_lookup_en, dac_power_en, step_pulse, step_down;
   logic               sweep_done, square_out_pin_o, square_out_pin_oe;
   logic               marker_pin_o, marker_pin_oe;
   int                 miscompares = 0;
   int                 checks_done = 0;
   int                 cycles = 0;
   int                 seed = 32'h07f4_b65b;
   int                 n, k, pulses, marks, gap, open;
   logic [11:0]        d;
   logic               p;
   logic [9:0]         hi_dac;
   logic [11:0]        tri_idx [5] = '{1, 2, 1, 0, 1};

   sweep_host_model host (.core_clk(core_clk), .word_valid(word_valid),
      .word_in(word_in));

   sweep_mode_control dut (.core_clk(core_clk), .reset(reset),
      .clk_en(clk_en), .word_valid(word_valid), .word_in(word_in),
      .params(params), .trigger_pin(trigger_pin),
      .out_cycle_tick(out_cycle_tick), .phase_word(phase_word),
      .sine_value(sine_value), .mode_word(mode_word),
      .sine_lookup_en(sine_lookup_en), .dac_code(dac_code),
      .dac_power_en(dac_power_en), .step_pulse(step_pulse),
      .step_index(step_index), .step_down(step_down),
      .sweep_done(sweep_done), .square_out_pin_o(square_out_pin_o),
      .square_out_pin_oe(square_out_pin_oe), .marker_pin_o(marker_pin_o),
      .marker_pin_oe(marker_pin_oe));

   ////////////////////////////////////////////////////////////////////////
   always #20 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      phase_word     <= phase_word + 12'h001;
      out_cycle_tick <= (phase_word == 12'hfff);
      cycles         <= cycles + 1;
      // Whole run needs well under 5000 cycles
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end

   function automatic logic [11:0] mw(input logic [8:0] b);
      return {1'b0, b, 2'b11};
   endfunction

   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Pin high 12 cycles, then low 8; one rise per call
   task automatic pin_cycle();
      trigger_pin = 1'b1;
      repeat (12) @(posedge core_clk);
      #1;
      hi_dac      = dac_code;
      trigger_pin = 1'b0;
      repeat (8) @(posedge core_clk);
      #1;
   endtask

   task automatic summarize();
      if (miscompares == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      params.step_count    = 12'h002;
      params.step_interval = 11'h005;
      params.gate_interval = 11'h002;
      repeat (10) @(posedge core_clk);
      #1;
      reset = 1'b0;
      check(mode_word, MODE_WORD_RESET);
      check({marker_pin_oe, square_out_pin_oe}, 12'h000);
      check(dac_code, 12'h200);
      for (n = 0; n < 12; n++) begin
         d = mw(9'($random(seed)));
         host.send(4'h0, d);
         p = phase_word[11];
         check(mode_word, d);
         check(sine_lookup_en, d[9]);
         check(square_out_pin_oe, d[8]);
         check(marker_pin_oe, d[2]);
         check(dac_power_en, d[10]);
         check(dac_code, 12'h200);
         check(step_index, 12'h000);
         @(posedge core_clk);
         #1;
         check(square_out_pin_o, p);
         host.send(4'(n + 1), 12'($random(seed)));
         check(mode_word, d);
         clk_en = 1'b0;
         host.send(4'h0, ~d);
         clk_en = 1'b1;
         check(mode_word, d);
      end
      // Sawtooth, external steps, step marker then end marker
      for (k = 0; k < 2; k++) begin
         host.send(4'h0, mw({4'b1111, 3'b011, k[0], 1'b1}));
         pin_cycle();
         check(step_index, 12'h000);
         for (n = 1; n <= 3; n++) begin
            pulses = 0;
            marks  = 0;
            trigger_pin = 1'b1;
            repeat (12) begin
               @(posedge core_clk);
               #1;
               pulses += int'(step_pulse === 1'b1);
               marks  += int'(marker_pin_o === 1'b1);
            end
            trigger_pin = 1'b0;
            repeat (6) @(posedge core_clk);
            #1;
            check(12'(pulses), 12'h001);
            // End step holds the last index one more window
            check(step_index, 12'((n > 2) ? 2 : n));
            check(dac_code, {2'b00, sine_value});
            if (k == 0) check(12'(marks), 12'h004);
            if (k == 1) check(marker_pin_o, n == 3);
            if (n == 3) check(sweep_done, 12'h001);
         end
      end
      // Triangle sweep goes up, turns down, then up again
      host.send(4'h0, mw(9'b1_1110_1000));
      pin_cycle();
      for (n = 0; n < 5; n++) begin
         pin_cycle();
         check(step_index, tri_idx[n]);
         if (n == 2) check(step_down, 12'h001);
         if (n == 3) check(sweep_done, 12'h001);
      end
      // Internal timing, gated; gate source must be ignored either way
      for (k = 0; k < 2; k++) begin
         host.send(4'h0, mw({4'b1110, k[0], 4'b0000}));
         pin_cycle();
         for (n = 0; n < 40 && step_pulse !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
         end
         gap  = 0;
         open = 0;
         do begin
            @(posedge core_clk);
            #1;
            gap++;
            open += int'(dac_code === {2'b00, sine_value});
         end while (step_pulse !== 1'b1 && gap < 40);
         check(12'(gap), 12'h005);
         check(12'(open), 12'h002);
         check(12'(gap - open), 12'h003);
      end
      // External stepping and external gate: output follows the pin
      host.send(4'h0, mw(9'b1_1101_1000));
      pin_cycle();
      pin_cycle();
      check(hi_dac, {2'b00, sine_value});
      check(dac_code, 12'h200);
      summarize();
   end
endmodule // sweep_mode_control_bench
